// *** srgc_regs.svh ***
// Timing constants for the synchronous-rectifier gate control block.
// Assumes a single 25 MHz clock; all durations are converted to cycles here.
// Functional notes
// R1 - Turn on when sense below turn-on level
// R2 - Each turn-on starts the on guard period
// R3 - On guard length from resistor or fixed
// R4 - Sense above turn-off level ends drive
// R5 - Off guard starts when sense above rearm
// R6 - Off guard length from resistor or fixed
// R7 - Ringing below rearm restarts off guard
// R8 - Rearm comparator retriggers off guard repeatedly
// R9 - No turn-on before off guard expires
// R10 - Trigger turns drive off within bounded delay
// R11 - Trigger ignored during blanking after turn-on
// R12 - Trigger outranks sense outside blanking
// R13 - Trigger high turns off, blocks turn-on
// R14 - Trigger held high long enters sleep
// R15 - Trigger low long enough leaves sleep
// R16 - Primary side keeps switch overlap short
// R17 - Early turn-off level waits for guard end
// R18 - Trigger turn-off overrides on guard period
// R19 - Drive low in and entering sleep
// R20 - After sleep: full off guard, next edge
// R21 - Inputs digital, timers are counters
`ifndef SRGC_REGS_SVH
`define SRGC_REGS_SVH

`define SRGC_CLK_NS 40
`define SRGC_MIN_CYC(ns) (((ns) + `SRGC_CLK_NS - 1) / `SRGC_CLK_NS)

`define SRGC_ON_GUARD_T1_NS  200
`define SRGC_ON_GUARD_T2_NS  400
`define SRGC_ON_GUARD_T3_NS  800
`define SRGC_OFF_GUARD_T1_NS 120
`define SRGC_OFF_GUARD_T2_NS 240
`define SRGC_OFF_GUARD_T3_NS 480
`define SRGC_BLANK_NS        120
`define SRGC_SLEEP_ENTRY_NS  20000
`define SRGC_SLEEP_EXIT_NS   2000

`define SRGC_ON_GUARD_C1  16'(`SRGC_MIN_CYC(`SRGC_ON_GUARD_T1_NS))
`define SRGC_ON_GUARD_C2  16'(`SRGC_MIN_CYC(`SRGC_ON_GUARD_T2_NS))
`define SRGC_ON_GUARD_C3  16'(`SRGC_MIN_CYC(`SRGC_ON_GUARD_T3_NS))
`define SRGC_OFF_GUARD_C1 16'(`SRGC_MIN_CYC(`SRGC_OFF_GUARD_T1_NS))
`define SRGC_OFF_GUARD_C2 16'(`SRGC_MIN_CYC(`SRGC_OFF_GUARD_T2_NS))
`define SRGC_OFF_GUARD_C3 16'(`SRGC_MIN_CYC(`SRGC_OFF_GUARD_T3_NS))
`define SRGC_BLANK_CYC    16'(`SRGC_MIN_CYC(`SRGC_BLANK_NS))
`define SRGC_ENTRY_CYC    16'(`SRGC_MIN_CYC(`SRGC_SLEEP_ENTRY_NS))
`define SRGC_EXIT_CYC     16'(`SRGC_MIN_CYC(`SRGC_SLEEP_EXIT_NS))

`endif

// *** srgc_pkg.sv ***
// Types shared by the gate control block and its timer.
// Assumes nothing beyond the constants header.
package srgc_pkg;

  typedef logic [15:0] srgc_cnt_t;

  typedef struct packed {
    logic below_on;
    logic above_off;
    logic above_rearm;
  } srgc_sense_t;

  typedef struct packed {
    logic [1:0] sel;
    srgc_cnt_t  ext_cycles;
  } srgc_guard_cfg_t;

  typedef enum logic [2:0] {
    SRGC_SLEEP,
    SRGC_OFF,
    SRGC_READY,
    SRGC_ON
  } srgc_state_t;

endpackage

// *** srgc_timer.sv ***
// Up-counter with a terminal count, cleared whenever run is low.
// Assumes tc is at least one and steady while run is high.
`timescale 1ns/1ps
module srgc_timer
  import srgc_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      rst,
  // Control
  input  wire logic      run,
  input  wire srgc_cnt_t tc,
  // Status
  output logic           done
);

  srgc_cnt_t cnt_q;

  always_ff @(posedge clk) begin
    if (rst || !run) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q != tc) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign done = run && (cnt_q == tc);

endmodule

// *** srgc_ctrl.sv ***
// Gate control for a secondary-side synchronous-rectifier transistor.
// Assumes comparator results and the trigger level arrive synchronous to clk.
`timescale 1ns/1ps
`include "srgc_regs.svh"
module srgc_ctrl
  import srgc_pkg::*;
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst,
  // Comparator results on the sense input
  input  wire srgc_sense_t     zero_current_comparator,
  // Trigger and sleep request from the primary side
  input  wire logic            trigger_sleep_input,
  // Guard period selection, sel 0 takes the resistor-derived count
  input  wire srgc_guard_cfg_t on_guard_set_resistor,
  input  wire srgc_guard_cfg_t off_guard_set_resistor,
  // Outputs
  output logic                 gate_drive_output,
  output logic                 sleep_mode
);

  function automatic srgc_cnt_t pick_tc(input srgc_guard_cfg_t cfg,
                                        input srgc_cnt_t f1,
                                        input srgc_cnt_t f2,
                                        input srgc_cnt_t f3);
    srgc_cnt_t r;
    r = f1;
    if (cfg.sel == 2'd0) begin
      r = (cfg.ext_cycles == 16'h0000) ? 16'h0001 : cfg.ext_cycles;
    end else if (cfg.sel == 2'd1) begin
      r = f1;
    end else if (cfg.sel == 2'd2) begin
      r = f2;
    end else begin
      r = f3;
    end
    return r;
  endfunction

  srgc_state_t state_q;
  srgc_state_t state_d;
  logic        gate_q;
  logic        below_on_q;
  logic        on_edge;
  logic        on_done;
  logic        off_done;
  logic        blank_done;
  logic        entry_done;
  logic        exit_done;
  logic        blanking;
  logic        trig_eff;
  logic        off_run;
  srgc_cnt_t   on_tc;
  srgc_cnt_t   off_tc;

  assign on_tc  = pick_tc(on_guard_set_resistor, `SRGC_ON_GUARD_C1,
                          `SRGC_ON_GUARD_C2, `SRGC_ON_GUARD_C3); // R3
  assign off_tc = pick_tc(off_guard_set_resistor, `SRGC_OFF_GUARD_C1,
                          `SRGC_OFF_GUARD_C2, `SRGC_OFF_GUARD_C3); // R6

  // Turn-on follows a fresh crossing, so a level already low never re-fires
  always_ff @(posedge clk) begin
    if (rst) begin
      below_on_q <= 1'b0;
    end else begin
      below_on_q <= zero_current_comparator.below_on;
    end
  end
  assign on_edge = zero_current_comparator.below_on && !below_on_q;

  // Off guard only counts while sense sits above the rearm level
  assign off_run = (state_q == SRGC_OFF)
                   && zero_current_comparator.above_rearm; // R5 R7 R8

  srgc_timer u_on_guard (
    .clk  (clk),
    .rst  (rst),
    .run  (state_q == SRGC_ON),
    .tc   (on_tc),
    .done (on_done)
  ); // R2 R21
  srgc_timer u_off_guard (
    .clk  (clk),
    .rst  (rst),
    .run  (off_run),
    .tc   (off_tc),
    .done (off_done)
  ); // R21
  srgc_timer u_blank (
    .clk  (clk),
    .rst  (rst),
    .run  (state_q == SRGC_ON),
    .tc   (`SRGC_BLANK_CYC),
    .done (blank_done)
  ); // R11
  srgc_timer u_entry (
    .clk  (clk),
    .rst  (rst),
    .run  (trigger_sleep_input && state_q != SRGC_SLEEP),
    .tc   (`SRGC_ENTRY_CYC),
    .done (entry_done)
  ); // R14
  srgc_timer u_exit (
    .clk  (clk),
    .rst  (rst),
    .run  (!trigger_sleep_input && state_q == SRGC_SLEEP),
    .tc   (`SRGC_EXIT_CYC),
    .done (exit_done)
  ); // R15

  // Blank holds from turn-on until its timer ends; the timer sticks at done
  assign blanking = (state_q == SRGC_ON) && !blank_done; // R11
  assign trig_eff = trigger_sleep_input && !blanking; // R12

  always_comb begin
    state_d = state_q;
    case (state_q)
      SRGC_SLEEP: begin
        if (exit_done) begin
          state_d = SRGC_OFF; // R15 R20
        end
      end
      SRGC_OFF: begin
        if (off_done) begin
          state_d = SRGC_READY; // R9
        end
      end
      SRGC_READY: begin
        if (on_edge && !trigger_sleep_input) begin
          state_d = SRGC_ON; // R1 R13 R20
        end
      end
      SRGC_ON: begin
        if (trig_eff) begin
          state_d = SRGC_OFF; // R10 R13 R18
        end else if (zero_current_comparator.above_off && on_done) begin
          state_d = SRGC_OFF; // R4 R17
        end
      end
      default: state_d = SRGC_OFF;
    endcase
    if (entry_done) begin
      state_d = SRGC_SLEEP; // R14 R19
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= SRGC_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Drive is a flop so it leaves the block glitch-free
  always_ff @(posedge clk) begin
    if (rst) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= (state_d == SRGC_ON);
    end
  end
  assign gate_drive_output = gate_q;
  assign sleep_mode        = (state_q == SRGC_SLEEP);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_trig_hit;
    (state_q == SRGC_ON) && trigger_sleep_input && !blanking && !entry_done;
  endsequence

  sequence s_drive_low_two;
    (!gate_drive_output) [*2];
  endsequence

  AST_TURN_ON: assert property ( // R1
    (state_q == SRGC_READY) && on_edge && !trigger_sleep_input && !entry_done
    |=> gate_drive_output)
    else $error("Drive did not turn on at sense crossing");
  AST_GUARD_HOLD: assert property ( // R17
    (state_q == SRGC_ON) && !on_done && !trig_eff && !entry_done
    |=> gate_drive_output)
    else $error("Drive dropped inside on guard");
  AST_SENSE_OFF: assert property ( // R4
    (state_q == SRGC_ON) && zero_current_comparator.above_off && on_done
    |=> !gate_drive_output)
    else $error("Drive stayed on past turn-off level");
  AST_TRIG_OFF: assert property ( // R10
    s_trig_hit |=> !gate_drive_output)
    else $error("Trigger did not end drive in one cycle");
  AST_BLANK: assert property ( // R11
    $rose(gate_drive_output) |-> blanking)
    else $error("Blanking not active at turn-on");
  AST_OFF_GUARD: assert property ( // R9
    (state_q == SRGC_OFF) |=> !gate_drive_output)
    else $error("Drive started inside off guard");
  AST_REARM_CLR: assert property ( // R7
    (state_q == SRGC_OFF) && !zero_current_comparator.above_rearm
    |=> !off_done)
    else $error("Off guard ran below rearm level");
  AST_TRIG_BLOCK: assert property ( // R13
    (state_q == SRGC_READY) && trigger_sleep_input
    |=> !gate_drive_output)
    else $error("Drive turned on while trigger high");
  AST_SLEEP_LOW: assert property ( // R19
    sleep_mode |-> !gate_drive_output)
    else $error("Drive high in sleep");
  AST_SLEEP_ENTRY: assert property ( // R14
    entry_done |=> sleep_mode ##0 !gate_drive_output)
    else $error("Sleep not entered after entry time");
  AST_SLEEP_EXIT: assert property ( // R15
    sleep_mode && exit_done |=> state_q == SRGC_OFF)
    else $error("Sleep not left after exit time");
  AST_RECOVER: assert property ( // R20
    $fell(sleep_mode) |-> s_drive_low_two)
    else $error("Drive rose straight out of sleep");

endmodule

// *** srgc_far_side.sv ***
// Primary-side trigger source facing the gate control block.
// Assumes the bench raises trig_req only where the test wants overlap.
`timescale 1ns/1ps
module srgc_far_side (
  // Request from the bench
  input  wire logic trig_req,
  // Trigger line into the block
  output logic      trigger_sleep_input
);
  // Pulses pass straight through, so any overlap stays as short as asked
  assign trigger_sleep_input = trig_req;
endmodule

// *** srgc_tb.sv ***
// Self-checking bench for the synchronous-rectifier gate control block.
// Assumes a 25 MHz clock and the cycle counts of the constants header.
`timescale 1ns/1ps
module testbench;
  import srgc_pkg::*;
  logic            clk;
  logic            rst;
  srgc_sense_t     sense;
  logic            trig_req;
  logic            trig;
  srgc_guard_cfg_t on_cfg;
  srgc_guard_cfg_t off_cfg;
  logic            gate;
  logic            sleep;
  int              num_errors;
  int              n_compared;
  int              cycles;
  int              n;

  srgc_ctrl u_dut (
    .clk                    (clk),
    .rst                    (rst),
    .zero_current_comparator(sense),
    .trigger_sleep_input    (trig),
    .on_guard_set_resistor  (on_cfg),
    .off_guard_set_resistor (off_cfg),
    .gate_drive_output      (gate),
    .sleep_mode             (sleep)
  );
  srgc_far_side u_far (
    .trig_req           (trig_req),
    .trigger_sleep_input(trig)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chkn(input string what, input int exp, input int got);
    n_compared++;
    if (got != exp) begin
      num_errors++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // Sense sits above the rearm level for k cycles
  task automatic arm(input int k);
    sense = 3'b001;
    cyc(k);
  endtask
  // Sense falls below the turn-on level
  task automatic fire();
    sense = 3'b100;
    cyc(1);
  endtask
  task automatic conclude();
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic t_guards();
    int onc[4];
    int offc[4];
    onc = '{7, 5, 10, 20};
    offc = '{4, 3, 6, 12};
    for (int s = 0; s < 4; s++) begin
      on_cfg = {2'(s), 16'h0007};
      off_cfg = {2'(s), 16'h0004};
      arm(offc[s] - 1);
      sense = 3'b000;
      cyc(1);
      fire();
      chk("gate early", 1'b0, gate);
      arm(offc[s] + 2);
      fire();
      chk("gate on", 1'b1, gate);
      // Turn-off level seen at once, drive must hold for the guard
      sense = 3'b010;
      n = 0;
      while (gate === 1'b1 && n < 40) begin
        n++;
        cyc(1);
      end
      chkn("on guard length", onc[s] + 1, n);
    end
  endtask

  task automatic t_ring();
    on_cfg = {2'd1, 16'h0000};
    off_cfg = {2'd1, 16'h0000};
    // Ringing keeps restarting the off guard before it can expire
    for (int i = 0; i < 3; i++) begin
      arm(2);
      sense = 3'b000;
      cyc(1);
    end
    arm(2);
    fire();
    chk("gate ringing", 1'b0, gate);
    arm(5);
    fire();
    chk("gate rearmed", 1'b1, gate);
    sense = 3'b000;
    cyc(6);
    chk("gate held", 1'b1, gate);
    sense = 3'b010;
    cyc(1);
    chk("gate sense off", 1'b0, gate);
  endtask

  task automatic t_trigger();
    arm(5);
    fire();
    trig_req = 1'b1;
    cyc(2);
    chk("gate blanked", 1'b1, gate);
    cyc(2);
    chk("gate trig off", 1'b0, gate);
    arm(5);
    fire();
    chk("gate trig block", 1'b0, gate);
    trig_req = 1'b0;
    sense = 3'b000;
    cyc(1);
  endtask

  task automatic t_sleep();
    trig_req = 1'b1;
    cyc(490);
    chk("sleep early", 1'b0, sleep);
    chk("gate entering", 1'b0, gate);
    cyc(15);
    chk("sleep entered", 1'b1, sleep);
    fire();
    chk("gate asleep", 1'b0, gate);
    trig_req = 1'b0;
    sense = 3'b000;
    cyc(40);
    chk("sleep short low", 1'b1, sleep);
    trig_req = 1'b1;
    cyc(1);
    trig_req = 1'b0;
    cyc(55);
    chk("sleep left", 1'b0, sleep);
    fire();
    chk("gate no guard", 1'b0, gate);
    arm(5);
    fire();
    chk("gate recovered", 1'b1, gate);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    num_errors = 0;
    n_compared = 0;
    cycles = 0;
    rst = 1'b1;
    sense = 3'b000;
    trig_req = 1'b0;
    on_cfg = {2'd1, 16'h0000};
    off_cfg = {2'd1, 16'h0000};
    cyc(12);
    rst = 1'b0;
    chk("gate after reset", 1'b0, gate);
    t_guards();
    t_ring();
    t_trigger();
    t_sleep();
    conclude();
  end
endmodule
